// *** wlw_pkg.sv ***
package wlw_pkg;
  // service register values
  localparam logic [7:0] SVC_KEY = 8'hac;
  localparam logic [7:0] SVC_RD_RUN = 8'h9a;
  localparam logic [7:0] SVC_RD_STOP = 8'h1a;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_SERVICE = 8'h00;
  localparam logic [7:0] OFF_CAUSE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_MEM_SIZE = 8'h10;
  localparam logic [7:0] OFF_EXP_RAM = 8'h14;
  localparam logic [7:0] OFF_VIEW = 8'h18;

  // option byte field positions
  localparam int OPT_OPEN_HI = 6;
  localparam int OPT_OPEN_LO = 5;
  localparam int OPT_RUN = 4;
  localparam int OPT_OVF_HI = 3;
  localparam int OPT_OVF_LO = 1;

  // overflow length is 2^(OVF_EXP_BASE + select) slow clock periods
  localparam int OVF_EXP_BASE = 10;
  localparam int CNT_W = 17;

  localparam int CAUSE_WDT_BIT = 4;

  // data accesses in these ranges are never flagged
  localparam logic [15:0] EXEMPT_A_LO = 16'hfb00;
  localparam logic [15:0] EXEMPT_A_HI = 16'hffcf;
  localparam logic [15:0] EXEMPT_B_LO = 16'hffe0;

  // memory area and mask register reset values
  localparam logic [7:0] MEM_SIZE_RST = 8'hc0;
  localparam logic [7:0] EXP_RAM_RST = 8'hf0;
  localparam logic [5:0] MASK_RST = 6'h00;

  // event bit positions in status and mask
  localparam int EV_OVF = 0;
  localparam int EV_BITOP = 1;
  localparam int EV_KEY = 2;
  localparam int EV_CLOSED = 3;
  localparam int EV_FETCH = 4;
  localparam int EV_ACCESS = 5;
  localparam int EV_W = 6;

  typedef struct packed {
    logic [1:0] open_sel;
    logic run;
    logic [2:0] ovf_sel;
  } wlw_opt_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } wlw_acc_t;
endpackage : wlw_pkg

// *** wlw_tick_gen.sv ***
`timescale 1ns/1ps
module wlw_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow_clk_pin,
  output logic tick
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic tick_q;

  // first flop feeds only the second; edge taken after the pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      meta_q <= slow_clk_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
      tick_q <= sync_q & ~prev_q;
    end
  end

  assign tick = tick_q;
endmodule : wlw_tick_gen

// *** wlw_watchdog.sv ***
`timescale 1ns/1ps
module wlw_watchdog (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_manip,
  input wire logic slow_clk_pin,
  input wire logic [7:0] option_byte_pin,
  input wire wlw_pkg::wlw_acc_t fetch_acc,
  input wire wlw_pkg::wlw_acc_t data_acc,
  output logic wdt_rst_req,
  output logic irq
);
  localparam int OVF_W = wlw_pkg::CNT_W + 1;

  // full overflow length in slow periods
  function automatic logic [OVF_W-1:0] ovf_len(input logic [2:0] sel);
    ovf_len = OVF_W'(1) << (wlw_pkg::OVF_EXP_BASE + int'(sel));
  endfunction : ovf_len

  // count below which the window stays closed
  function automatic logic [OVF_W-1:0] closed_len(input logic [1:0] open_sel,
                                                  input logic [2:0] sel);
    logic [OVF_W-1:0] full;
    full = ovf_len(sel);
    case (open_sel)
      2'b00: closed_len = full >> 1;
      2'b01: closed_len = full >> 2;
      2'b10: closed_len = full >> 3;
      default: closed_len = '0;
    endcase
  endfunction : closed_len

  logic tick;
  logic [7:0] opt_meta_v_q;
  logic [7:0] opt_sync_q;
  logic [1:0] cap_cnt_q;
  logic captured_q;
  wlw_pkg::wlw_opt_t opt_q;
  logic [wlw_pkg::CNT_W-1:0] cnt_q;
  logic [wlw_pkg::CNT_W-1:0] cnt_d;
  logic first_done_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [wlw_pkg::EV_W-1:0] status_q;
  logic [wlw_pkg::EV_W-1:0] status_d;
  logic [wlw_pkg::EV_W-1:0] mask_q;
  logic [7:0] cause_q;
  logic [7:0] mem_size_q;
  logic [7:0] exp_ram_q;
  logic rst_req_q;
  logic irq_q;

  wlw_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .slow_clk_pin(slow_clk_pin),
    .tick(tick)
  );

  // option pins are sampled twice, then frozen a few cycles after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_meta_v_q <= 8'h00;
      opt_sync_q <= 8'h00;
      cap_cnt_q <= 2'h0;
      captured_q <= 1'b0;
      opt_q <= '0;
    end else begin
      opt_meta_v_q <= option_byte_pin;
      opt_sync_q <= opt_meta_v_q;
      if (!captured_q) begin
        cap_cnt_q <= cap_cnt_q + 2'h1;
        if (cap_cnt_q == 2'h3) begin
          captured_q <= 1'b1;
          opt_q.open_sel <= opt_sync_q[wlw_pkg::OPT_OPEN_HI:
                                       wlw_pkg::OPT_OPEN_LO];
          opt_q.run <= opt_sync_q[wlw_pkg::OPT_RUN];
          opt_q.ovf_sel <= opt_sync_q[wlw_pkg::OPT_OVF_HI:
                                      wlw_pkg::OPT_OVF_LO];
        end
      end
    end
  end
  // bus decode
  wire running = captured_q & opt_q.run;
  wire acc_ph = psel & penable;
  wire commit = acc_ph & pready_q;
  wire wr_commit = commit & pwrite;
  wire rd_commit = commit & ~pwrite;
  wire hit_svc = paddr == wlw_pkg::OFF_SERVICE;
  wire hit_cause = paddr == wlw_pkg::OFF_CAUSE;
  wire hit_status = paddr == wlw_pkg::OFF_STATUS;
  wire hit_mask = paddr == wlw_pkg::OFF_MASK;
  wire hit_mem = paddr == wlw_pkg::OFF_MEM_SIZE;
  wire hit_exp = paddr == wlw_pkg::OFF_EXP_RAM;
  wire hit_view = paddr == wlw_pkg::OFF_VIEW;
  wire mapped = hit_svc | hit_cause | hit_status | hit_mask | hit_mem |
                hit_exp | hit_view;
  wire svc_wr = wr_commit & hit_svc;

  // window and overflow
  wire [OVF_W-1:0] cnt_ext = {1'b0, cnt_q};
  wire [OVF_W-1:0] last_cnt = ovf_len(opt_q.ovf_sel) - OVF_W'(1);
  wire win_closed = first_done_q &
                    (cnt_ext < closed_len(opt_q.open_sel, opt_q.ovf_sel));
  wire svc_ok = svc_wr & ~bit_manip & (pwdata[7:0] == wlw_pkg::SVC_KEY);

  // memory area checks; fetch below the program limit, data also in RAM
  wire [15:0] prog_limit = {mem_size_q, 8'h00};
  wire [15:0] ram_base = {exp_ram_q, 8'h00};
  wire fetch_ok = fetch_acc.addr < prog_limit;
  wire data_ok = (data_acc.addr < prog_limit) | (data_acc.addr >= ram_base);
  wire exempt = ((data_acc.addr >= wlw_pkg::EXEMPT_A_LO) &
                 (data_acc.addr <= wlw_pkg::EXEMPT_A_HI)) |
                (data_acc.addr >= wlw_pkg::EXEMPT_B_LO);

  wire [wlw_pkg::EV_W-1:0] ev;
  assign ev[wlw_pkg::EV_OVF] = running & tick & ~svc_ok &
                               (cnt_ext == last_cnt);
  assign ev[wlw_pkg::EV_BITOP] = running & svc_wr & bit_manip;
  assign ev[wlw_pkg::EV_KEY] = running & svc_wr & ~bit_manip &
                               (pwdata[7:0] != wlw_pkg::SVC_KEY);
  assign ev[wlw_pkg::EV_CLOSED] = running & svc_wr & win_closed;
  assign ev[wlw_pkg::EV_FETCH] = running & fetch_acc.valid & ~fetch_ok;
  assign ev[wlw_pkg::EV_ACCESS] = running & data_acc.valid & ~data_ok &
                                  ~exempt;
  wire any_ev = |ev;

  // counter; a service clear beats a same-cycle tick
  always_comb begin
    cnt_d = cnt_q;
    if (svc_ok && running) begin
      cnt_d = '0;
    end else if (running && tick) begin
      cnt_d = cnt_q + wlw_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      first_done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (svc_wr && running) begin
        first_done_q <= 1'b1;
      end
    end
  end

  // sticky events, cleared by a read; a new event wins over the clear
  wire status_rd = rd_commit & hit_status;
  always_comb begin
    status_d = status_q;
    if (status_rd) begin
      status_d = '0;
    end
    status_d = status_d | ev;
  end

  // reset request is held until the chip reset takes this block down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      rst_req_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      rst_req_q <= rst_req_q | any_ev;
      irq_q <= |(status_d & mask_q);
    end
  end

  // cause flag stays visible until software clears it or presetn resets this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= 8'h00;
    end else if (any_ev) begin
      cause_q[wlw_pkg::CAUSE_WDT_BIT] <= 1'b1;
    end else if (wr_commit && hit_cause) begin
      cause_q <= 8'h00;
    end
  end

  // writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= wlw_pkg::MASK_RST;
      mem_size_q <= wlw_pkg::MEM_SIZE_RST;
      exp_ram_q <= wlw_pkg::EXP_RAM_RST;
    end else if (wr_commit) begin
      if (hit_mask) begin
        mask_q <= pwdata[wlw_pkg::EV_W-1:0];
      end
      if (hit_mem) begin
        mem_size_q <= pwdata[7:0];
      end
      if (hit_exp) begin
        exp_ram_q <= pwdata[7:0];
      end
    end
  end

  // read mux; the written key is never echoed back
  wire [7:0] svc_rd = running ? wlw_pkg::SVC_RD_RUN :
                                wlw_pkg::SVC_RD_STOP;
  // 6 option bits, run, window and 17 count bits fill the low 25 bits
  wire [31:0] view_rd = {7'h00, opt_q, running, win_closed, cnt_q};
  wire [31:0] rd_data =
    hit_svc ? {24'h0, svc_rd} :
    hit_cause ? {24'h0, cause_q} :
    hit_status ? {26'h0, status_q} :
    hit_mask ? {26'h0, mask_q} :
    hit_mem ? {24'h0, mem_size_q} :
    hit_exp ? {24'h0, exp_ram_q} :
    hit_view ? view_rd : 32'h0;

  // one wait state: ready rises the cycle after the access phase begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc_ph & ~pready_q;
      pslverr_q <= acc_ph & ~pready_q & ~mapped;
      if (acc_ph && !pready_q) begin
        prdata_q <= pwrite ? 32'h0 : rd_data;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wdt_rst_req = rst_req_q;
  assign irq = irq_q;
endmodule : wlw_watchdog

// *** wlw_props.sv ***
`timescale 1ns/1ps
module wlw_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_manip,
  input wire logic slow_clk_pin,
  input wire logic [7:0] option_byte_pin,
  input wire wlw_pkg::wlw_acc_t fetch_acc,
  input wire wlw_pkg::wlw_acc_t data_acc,
  input wire logic wdt_rst_req,
  input wire logic irq
);
  logic [3:0] up_q;
  logic [3:0] up_d;
  logic up;
  logic live;
  // option byte is only trusted once captured after release
  assign up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
  assign up = up_q > 4'h8;
  assign live = up && option_byte_pin[wlw_pkg::OPT_RUN];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 4'h0;
    else up_q <= up_d;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence svc_wr;
    psel && penable && pwrite && !pready && paddr == wlw_pkg::OFF_SERVICE;
  endsequence
  sequence trip;
    ##[1:4] wdt_rst_req;
  endsequence
  req_held_a: assert property (wdt_rst_req |=> wdt_rst_req)
    else $error("reset request dropped");
  bitop_trip_a: assert property ((live && bit_manip) ##0 svc_wr |-> trip)
    else $error("bit write did not trip");
  bad_key_a: assert property
    ((live && pwdata[7:0] != wlw_pkg::SVC_KEY) ##0 svc_wr |-> trip)
    else $error("bad key did not trip");
  fetch_trip_a: assert property (live && fetch_acc.valid
    && fetch_acc.addr[15:8] >= wlw_pkg::MEM_SIZE_RST |-> ##[1:3] wdt_rst_req)
    else $error("fetch did not trip");
  gap_access_a: assert property (live && data_acc.valid
    && data_acc.addr[15:8] >= wlw_pkg::MEM_SIZE_RST
    && data_acc.addr[15:12] < 4'hf |-> ##[1:3] wdt_rst_req)
    else $error("access did not trip");
  irq_cause_a: assert property (irq |-> wdt_rst_req)
    else $error("irq without cause");
  stop_quiet_a: assert property
    (up && !option_byte_pin[wlw_pkg::OPT_RUN] |-> !wdt_rst_req)
    else $error("stopped block tripped");
  svc_read_a: assert property (up && psel && !pwrite && pready
    && paddr == wlw_pkg::OFF_SERVICE |-> prdata[7:0] ==
    (option_byte_pin[wlw_pkg::OPT_RUN] ? 8'h9a : 8'h1a))
    else $error("service read value");
endmodule : wlw_props

bind wlw_watchdog wlw_props wlw_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bit_manip(bit_manip), .slow_clk_pin(slow_clk_pin),
  .option_byte_pin(option_byte_pin), .fetch_acc(fetch_acc),
  .data_acc(data_acc), .wdt_rst_req(wdt_rst_req), .irq(irq));

// *** wlw_cpu_model.sv ***
`timescale 1ns/1ps
module wlw_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic bit_manip,
  output wlw_pkg::wlw_acc_t fetch_acc,
  output wlw_pkg::wlw_acc_t data_acc
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bit_manip = 1'b0;
    fetch_acc = '0;
    data_acc = '0;
  end
  // released lines show inverted values so stale data cannot pass
  task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic bm, output logic [31:0] r,
      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    bit_manip <= bm;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bit_manip <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic service();
    logic [31:0] r;
    logic e;
    xfer(wlw_pkg::OFF_SERVICE, 1'b1, 32'hac, 1'b0, r, e);
  endtask : service
  task automatic touch(input logic [15:0] a, input logic dat);
    @(posedge pclk);
    fetch_acc <= '{!dat, a};
    data_acc <= '{dat, a};
    @(posedge pclk);
    fetch_acc <= '{1'b0, ~a};
    data_acc <= '{1'b0, ~a};
  endtask : touch
endmodule : wlw_cpu_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] option_byte_pin = 8'h00;
  logic [2:0] div_q = 3'h0;
  logic psel, penable, pwrite, pready, pslverr, bit_manip;
  logic wdt_rst_req, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  wlw_pkg::wlw_acc_t fetch_acc, data_acc;
  int failures = 0;
  int total_checks = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) div_q <= div_q + 3'h1;
  wlw_watchdog wlw_watchdog_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_manip(bit_manip), .slow_clk_pin(div_q[2]),
    .option_byte_pin(option_byte_pin), .fetch_acc(fetch_acc),
    .data_acc(data_acc), .wdt_rst_req(wdt_rst_req), .irq(irq));
  wlw_cpu_model wlw_cpu_model_inst (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_manip(bit_manip), .fetch_acc(fetch_acc), .data_acc(data_acc));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic boot(input logic [7:0] opt);
    presetn <= 1'b0;
    option_byte_pin <= opt;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : boot
  task automatic rw(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic bm, output logic [31:0] r);
    logic e;
    wlw_cpu_model_inst.xfer(a, w, d, bm, r, e);
    check({31'h0, e}, {31'h0, a > 8'h18});
  endtask : rw
  task automatic quiet();
    repeat (6) @(posedge pclk);
    check({31'h0, wdt_rst_req}, 32'h0);
  endtask : quiet
  // waits for the request, then checks cause, status and irq
  task automatic trip(input int ev, input logic ie, input int lim);
    logic [31:0] r;
    int n;
    n = 0;
    while (wdt_rst_req !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, wdt_rst_req}, 32'h1);
    check({31'h0, irq}, {31'h0, ie});
    rw(wlw_pkg::OFF_CAUSE, 1'b0, 32'h0, 1'b0, r);
    check(r, 32'h10);
    rw(wlw_pkg::OFF_CAUSE, 1'b1, 32'h0, 1'b0, r);
    rw(wlw_pkg::OFF_CAUSE, 1'b0, 32'h0, 1'b0, r);
    check(r, 32'h0);
    rw(wlw_pkg::OFF_STATUS, 1'b0, 32'h0, 1'b0, r);
    check(r, 32'h1 << ev);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
  endtask : trip
  task automatic t_stop();
    logic [31:0] r;
    boot(8'h00);
    rw(wlw_pkg::OFF_SERVICE, 1'b0, 32'h0, 1'b0, r);
    check(r & 32'hff, 32'h1a);
    rw(wlw_pkg::OFF_SERVICE, 1'b1, 32'h55, 1'b0, r);
    wlw_cpu_model_inst.touch(16'hc000, 1'b0);
    wlw_cpu_model_inst.touch(16'hc000, 1'b1);
    quiet();
  endtask : t_stop
  task automatic t_key();
    logic [31:0] r;
    boot(8'h70);
    rw(wlw_pkg::OFF_SERVICE, 1'b0, 32'h0, 1'b0, r);
    check(r & 32'hff, 32'h9a);
    rw(wlw_pkg::OFF_VIEW, 1'b0, 32'h0, 1'b0, r);
    check(r >> 17, 32'he2);
    rw(wlw_pkg::OFF_MASK, 1'b1, 32'h3f, 1'b0, r);
    rw(8'h1c, 1'b0, 32'h0, 1'b0, r);
    check(r, 32'h0);
    wlw_cpu_model_inst.service();
    wlw_cpu_model_inst.service();
    quiet();
    rw(wlw_pkg::OFF_SERVICE, 1'b1, 32'h55, 1'b0, r);
    trip(wlw_pkg::EV_KEY, 1'b1, 8);
  endtask : t_key
  task automatic t_misc();
    logic [31:0] r;
    logic [15:0] ok_a [4] = '{16'hbfff, 16'hfb00, 16'hfdff, 16'hfe00};
    boot(8'h70);
    rw(wlw_pkg::OFF_SERVICE, 1'b1, 32'hac, 1'b1, r);
    trip(wlw_pkg::EV_BITOP, 1'b0, 8);
    boot(8'h12);
    wlw_cpu_model_inst.service();
    wlw_cpu_model_inst.service();
    trip(wlw_pkg::EV_CLOSED, 1'b0, 8);
    boot(8'h70);
    wlw_cpu_model_inst.touch(16'hbfff, 1'b0);
    quiet();
    wlw_cpu_model_inst.touch(16'hc000, 1'b0);
    trip(wlw_pkg::EV_FETCH, 1'b0, 8);
    boot(8'h70);
    wlw_cpu_model_inst.touch(16'hc000, 1'b1);
    trip(wlw_pkg::EV_ACCESS, 1'b0, 8);
    boot(8'h70);
    rw(wlw_pkg::OFF_EXP_RAM, 1'b1, 32'hfe, 1'b0, r);
    foreach (ok_a[i]) wlw_cpu_model_inst.touch(ok_a[i], 1'b1);
    quiet();
    wlw_cpu_model_inst.touch(16'hfaff, 1'b1);
    trip(wlw_pkg::EV_ACCESS, 1'b0, 8);
  endtask : t_misc
  task automatic t_ovf();
    boot(8'h70);
    repeat (4800) @(posedge pclk);
    wlw_cpu_model_inst.service();
    // 1020 slow edges of 8 clocks each after the clear
    repeat (8160) @(posedge pclk);
    check({31'h0, wdt_rst_req}, 32'h0);
    trip(wlw_pkg::EV_OVF, 1'b0, 64);
  endtask : t_ovf
  initial begin
    t_stop();
    t_key();
    t_misc();
    t_ovf();
    summarize();
  end
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule : tb
